// ===== verilog/branch_timing_pkg.sv
package branch_timing_pkg;
  // opcode encodings
  localparam logic [7:0] OP_ESCAPE      = 8'h00A5;
  localparam logic [7:0] OP_ORL_C_BIT   = 8'h0072;
  localparam logic [7:0] OP_ORL_C_NBIT  = 8'h00A0;
  localparam logic [7:0] OP_MOV_C_BIT   = 8'h00A2;
  localparam logic [7:0] OP_MOV_BIT_C   = 8'h0092;
  localparam logic [7:0] OP_JC          = 8'h0040;
  localparam logic [7:0] OP_JNC         = 8'h0050;
  localparam logic [7:0] OP_JB          = 8'h0020;
  localparam logic [7:0] OP_JNB         = 8'h0030;
  localparam logic [7:0] OP_JBC         = 8'h0010;
  localparam logic [7:0] OP_JZ          = 8'h0060;
  localparam logic [7:0] OP_JNZ         = 8'h0070;
  localparam logic [7:0] OP_SJMP        = 8'h0080;
  localparam logic [7:0] OP_LCALL       = 8'h0012;
  localparam logic [7:0] OP_RET         = 8'h0022;
  localparam logic [7:0] OP_RETI        = 8'h0032;
  localparam logic [7:0] OP_LJMP        = 8'h0002;
  localparam logic [7:0] OP_JMP_DPTR    = 8'h0073;
  localparam logic [7:0] OP_CMPJ_DIR    = 8'h00B5;
  localparam logic [7:0] OP_CMPJ_IMM    = 8'h00B4;
  localparam logic [7:0] OP_DJNZ_DIR    = 8'h00D5;
  localparam logic [7:0] OP_NOP         = 8'h0000;
  localparam logic [7:0] OP_XMOVE_RD_DP = 8'h00E0;
  localparam logic [7:0] OP_XMOVE_RD_RI = 8'h00E2;
  localparam logic [7:0] OP_XMOVE_WR_DP = 8'h00F0;
  localparam logic [7:0] OP_XMOVE_WR_RI = 8'h00F2;
  localparam logic [4:0] OP_AJMP_LOW    = 5'h0001;
  localparam logic [4:0] OP_ACALL_LOW   = 5'h0011;
  localparam logic [4:0] OP_CMPJ_RN_HI  = 5'h0017;
  localparam logic [4:0] OP_DJNZ_RN_HI  = 5'h001B;
  localparam logic [6:0] OP_CMPJ_RI_HI  = 7'h005B;
  // cycle counts per regime
  localparam logic [4:0] CYC_COMPAT_STD = 5'h000C;
  localparam logic [4:0] CYC_COMPAT_HALF = 5'h0006;
  localparam logic [4:0] CYC_COMPAT_ESC = 5'h0012;
  localparam logic [4:0] CYC_FAST_1     = 5'h0001;
  localparam logic [4:0] CYC_FAST_2     = 5'h0002;
  localparam logic [4:0] CYC_FAST_3     = 5'h0003;
  localparam logic [4:0] CYC_FAST_4     = 5'h0004;
  localparam logic [4:0] CYC_FAST_XMOVE = 5'h0002;
  localparam logic [4:0] CYC_COMPAT_XMV = 5'h0018;
  localparam logic [5:0] CYC_COMPAT_WAIT = 6'h0018;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  // clock divider defaults
  localparam logic [3:0] DIV_FAST_DEFAULT   = 4'h0001;
  localparam logic [3:0] DIV_COMPAT_DEFAULT = 4'h0002;
  typedef enum logic [1:0] {ST_FETCH, ST_ESCAPED, ST_EXEC} seq_state_t;
endpackage : branch_timing_pkg

// ===== verilog/cycle_divider.sv
`timescale 1ns/100ps
`default_nettype none
// divides the oscillator into instruction clock ticks
module cycle_divider #(
  parameter int DIV_W = 4
) (
  input  wire logic             sys_clk_i,  // oscillator clock
  input  wire logic             reset_n_i,  // sync reset, active low
  input  wire logic [DIV_W-1:0] divide_i,   // ticks every divide_i periods
  output logic                  tick_o      // one instruction clock cycle
);
  logic [DIV_W-1:0] count_r;
  logic [DIV_W-1:0] count_nxt;
  logic             last_w;

  initial begin
    if (DIV_W < 2) $error("divider width too small");
  end

  // divide of zero treated as one so the sequencer never starves
  assign last_w    = (count_r + 1'b1 >= divide_i) || (divide_i == '0);
  assign count_nxt = last_w ? '0 : DIV_W'(count_r + 1'b1);

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      count_r <= '0;
      tick_o  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_o  <= last_w;
    end
  end
endmodule // cycle_divider
`default_nettype wire

// ===== verilog/branch_timing.sv
`timescale 1ns/100ps
`default_nettype none
module branch_timing
  import branch_timing_pkg::*;
#(
  parameter int DIV_W = 4
) (
  input  wire logic             sys_clk_i,      // oscillator clock, 25 MHz
  input  wire logic             reset_n_i,      // sync reset, active low
  input  wire logic             fast_mode_i,    // 1 fast regime, 0 compatibility
  input  wire logic             div_override_i, // use div_value_i instead of default
  input  wire logic [DIV_W-1:0] div_value_i,    // explicit divider
  input  wire logic [1:0]       wait_states_i,  // external move wait states
  input  wire logic             op_valid_i,     // opcode byte offered
  input  wire logic [7:0]       op_byte_i,      // opcode byte
  output logic                  op_ready_o,     // byte accepted at the previous clock edge
  output logic                  busy_o,         // instruction executing
  output logic                  done_o,         // pulse at last cycle of instruction
  output logic [7:0]            op_code_o,      // decoded opcode byte
  output logic                  escaped_o,      // decoded op was escaped
  output logic [1:0]            op_len_o,       // instruction length in bytes
  output logic [5:0]            op_cycles_o,    // instruction cycles charged
  output logic                  illegal_o,      // escape followed by unknown byte
  output logic                  cycle_tick_o    // instruction clock tick
);
  import branch_timing_pkg::*;

  initial begin
    if (DIV_W < 2) $error("DIV_W must hold the compatibility divider");
  end

  seq_state_t state_r;
  logic [5:0] remain_r;
  logic [DIV_W-1:0] divide_w;
  logic tick_w;
  logic take_w;
  logic [1:0] len_w;
  logic [5:0] cyc_w;
  logic ext_ok_w;

  // divider default depends on the timing regime
  assign divide_w = div_override_i ? div_value_i :
                    fast_mode_i ? DIV_W'(DIV_FAST_DEFAULT) :
                    DIV_W'(DIV_COMPAT_DEFAULT);

  cycle_divider #(.DIV_W(DIV_W)) u_div (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .divide_i  (divide_w),
    .tick_o    (tick_w)
  );

  // length of an unprefixed opcode
  function automatic logic [1:0] plain_len(input logic [7:0] op);
    if (op[4:0] == OP_AJMP_LOW || op[4:0] == OP_ACALL_LOW) plain_len = LEN_2;
    else if (op[7:3] == OP_CMPJ_RN_HI || op[7:1] == OP_CMPJ_RI_HI) plain_len = LEN_3;
    else if (op[7:3] == OP_DJNZ_RN_HI) plain_len = LEN_2;
    else begin
      case (op)
        OP_JB, OP_JNB, OP_JBC, OP_LCALL, OP_LJMP,
        OP_CMPJ_DIR, OP_CMPJ_IMM, OP_DJNZ_DIR: plain_len = LEN_3;
        OP_JC, OP_JNC, OP_JZ, OP_JNZ, OP_SJMP,
        OP_ORL_C_BIT, OP_ORL_C_NBIT, OP_MOV_C_BIT, OP_MOV_BIT_C: plain_len = LEN_2;
        default: plain_len = LEN_1;
      endcase
    end
  endfunction

  // fast cycles of an unprefixed opcode
  function automatic logic [4:0] plain_fast(input logic [7:0] op);
    case (op)
      OP_RET, OP_RETI: plain_fast = CYC_FAST_4;
      OP_JMP_DPTR, OP_ORL_C_BIT, OP_ORL_C_NBIT,
      OP_MOV_C_BIT, OP_MOV_BIT_C: plain_fast = CYC_FAST_2;
      OP_NOP: plain_fast = CYC_FAST_1;
      OP_XMOVE_RD_DP, OP_XMOVE_RD_RI,
      OP_XMOVE_WR_DP, OP_XMOVE_WR_RI: plain_fast = CYC_FAST_XMOVE;
      default: plain_fast = (plain_len(op) == LEN_3) ? CYC_FAST_4 :
                            (plain_len(op) == LEN_2) ? CYC_FAST_3 : CYC_FAST_1;
    endcase
  endfunction

  // compatibility cycles of an unprefixed opcode
  function automatic logic [4:0] plain_compat(input logic [7:0] op);
    case (op)
      OP_MOV_C_BIT, OP_NOP: plain_compat = CYC_COMPAT_HALF;
      OP_XMOVE_RD_DP, OP_XMOVE_RD_RI,
      OP_XMOVE_WR_DP, OP_XMOVE_WR_RI: plain_compat = CYC_COMPAT_XMV;
      default: plain_compat = CYC_COMPAT_STD;
    endcase
  endfunction

  function automatic logic is_xmove(input logic [7:0] op);
    is_xmove = (op == OP_XMOVE_RD_DP) || (op == OP_XMOVE_RD_RI) ||
               (op == OP_XMOVE_WR_DP) || (op == OP_XMOVE_WR_RI);
  endfunction

  // escaped second byte: only three extensions are defined
  assign ext_ok_w = (op_byte_i == OP_JMP_DPTR) ||
                    (op_byte_i == {OP_CMPJ_RI_HI, 1'b0}) ||
                    (op_byte_i == {OP_CMPJ_RI_HI, 1'b1});

  // length and cost of the byte now offered
  logic [5:0] plain_cyc_w;
  logic [5:0] wait_cyc_w;
  assign wait_cyc_w = !is_xmove(op_byte_i) ? 6'h00 :
                      fast_mode_i ? {4'h0, wait_states_i} :
                      (wait_states_i != 2'h0) ? CYC_COMPAT_WAIT : 6'h00;
  assign plain_cyc_w = {1'b0, fast_mode_i ? plain_fast(op_byte_i)
                                          : plain_compat(op_byte_i)} + wait_cyc_w;

  always_comb begin
    len_w = plain_len(op_byte_i);
    cyc_w = plain_cyc_w;
    if (state_r == ST_ESCAPED) begin
      if (op_byte_i == OP_JMP_DPTR) begin
        len_w = LEN_2;
        cyc_w = {1'b0, fast_mode_i ? CYC_FAST_3 : CYC_COMPAT_STD};
      end else begin
        len_w = LEN_3;
        cyc_w = {1'b0, fast_mode_i ? CYC_FAST_4 : CYC_COMPAT_ESC};
      end
    end
  end

  // bytes taken only on an instruction tick while not executing
  assign take_w = op_valid_i && tick_w && (state_r != ST_EXEC);

  // sequencer: remain_r counts instruction cycles, one per divider tick
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_r     <= ST_FETCH;
      remain_r    <= 6'h00;
      op_ready_o  <= 1'b0;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      op_code_o   <= 8'h00;
      escaped_o   <= 1'b0;
      op_len_o    <= 2'h0;
      op_cycles_o <= 6'h00;
      illegal_o   <= 1'b0;
      cycle_tick_o <= 1'b0;
    end else begin
      op_ready_o   <= take_w;
      done_o       <= 1'b0;
      illegal_o    <= 1'b0;
      cycle_tick_o <= tick_w;
      case (state_r)
        ST_FETCH: begin
          if (take_w && op_byte_i == OP_ESCAPE) begin
            state_r <= ST_ESCAPED;
          end else if (take_w) begin
            state_r     <= ST_EXEC;
            busy_o      <= 1'b1;
            op_code_o   <= op_byte_i;
            escaped_o   <= 1'b0;
            op_len_o    <= len_w;
            op_cycles_o <= cyc_w;
            remain_r    <= 6'(cyc_w - 6'h01);
          end
        end
        ST_ESCAPED: begin
          if (take_w && !ext_ok_w) begin
            state_r   <= ST_FETCH;      // unknown extension dropped
            illegal_o <= 1'b1;
          end else if (take_w) begin
            state_r     <= ST_EXEC;
            busy_o      <= 1'b1;
            op_code_o   <= op_byte_i;
            escaped_o   <= 1'b1;
            op_len_o    <= len_w;
            op_cycles_o <= cyc_w;
            remain_r    <= 6'(cyc_w - 6'h01);
          end
        end
        ST_EXEC: begin
          if (tick_w) begin
            if (remain_r == 6'h00) begin
              state_r <= ST_FETCH;
              busy_o  <= 1'b0;
              done_o  <= 1'b1;
            end else begin
              remain_r <= 6'(remain_r - 6'h01);
            end
          end
        end
        default: state_r <= ST_FETCH;
      endcase
    end
  end
endmodule // branch_timing
`default_nettype wire

// ===== sim/branch_timing_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// watches the decoder's ports for timing and cost relations
module branch_timing_monitor (
  input wire logic       sys_clk_i,      // oscillator clock
  input wire logic       reset_n_i,      // sync reset, active low
  input wire logic       fast_mode_i,    // regime select
  input wire logic       div_override_i, // explicit divider in use
  input wire logic [1:0] wait_states_i,  // external move wait states
  input wire logic       op_ready_o,     // byte accepted
  input wire logic       busy_o,         // executing
  input wire logic       done_o,         // finished pulse
  input wire logic [7:0] op_code_o,      // decoded opcode
  input wire logic       escaped_o,      // prefixed op
  input wire logic [1:0] op_len_o,       // bytes
  input wire logic [5:0] op_cycles_o,    // cycles charged
  input wire logic       illegal_o,      // bad escape pulse
  input wire logic       cycle_tick_o    // divider tick
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // divider: five settled cycles before judging, so a regime switch may resync
  chk_fast_tick: assert property ((fast_mode_i && !div_override_i)[*5] |-> cycle_tick_o)
    else $error("fast regime tick missing");
  chk_compat_tick: assert property ((!fast_mode_i && !div_override_i)[*5]
    |-> cycle_tick_o != $past(cycle_tick_o)) else $error("compat tick not every second clock");
  chk_busy_ready: assert property ($rose(busy_o) |-> op_ready_o)
    else $error("busy without accepted byte");
  chk_busy_refuse: assert property (busy_o && $past(busy_o) && !$past(done_o) |-> !op_ready_o)
    else $error("byte taken while busy");
  chk_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than a clock");
  chk_done_bound: assert property ($rose(busy_o) |-> ##[1:400] done_o)
    else $error("instruction never finished");
  chk_illegal_idle: assert property (illegal_o |-> !busy_o) else $error("illegal escape executed");
  chk_esc_jump: assert property (busy_o && escaped_o && op_code_o == 8'h73
    |-> op_len_o == 2'h2 && op_cycles_o == (fast_mode_i ? 6'h03 : 6'h0C)) else $error("escaped jump cost");
  chk_esc_compare: assert property (busy_o && escaped_o && op_code_o[7:1] == 7'h5B
    |-> op_len_o == 2'h3 && op_cycles_o == (fast_mode_i ? 6'h04 : 6'h12)) else $error("escaped compare cost");
  chk_xmove_wait: assert property (busy_o && !escaped_o && op_code_o[7:5] == 3'b111
    && op_code_o[3:2] == 2'b00 && !op_code_o[0] |-> op_cycles_o ==
    (fast_mode_i ? 6'h02 + {4'h0, wait_states_i} : (wait_states_i != 2'h0 ? 6'h30 : 6'h18)))
    else $error("external move cost");
endmodule // branch_timing_monitor
bind branch_timing branch_timing_monitor u_monitor (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .fast_mode_i(fast_mode_i), .div_override_i(div_override_i), .wait_states_i(wait_states_i),
  .op_ready_o(op_ready_o), .busy_o(busy_o), .done_o(done_o), .op_code_o(op_code_o),
  .escaped_o(escaped_o), .op_len_o(op_len_o), .op_cycles_o(op_cycles_o), .illegal_o(illegal_o),
  .cycle_tick_o(cycle_tick_o));
`default_nettype wire

// ===== sim/tb_branch_timing.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
module tb_branch_timing;
  import branch_timing_pkg::*;
  typedef struct packed {logic esc; logic [7:0] op; logic [1:0] ln; logic [5:0] cc; logic [5:0] fc;} row_t;
  logic       sys_clk_i = 1'b0, reset_n_i = 1'b0, fast_mode_i = 1'b0, div_override_i = 1'b1;
  logic       op_valid_i = 1'b0, op_ready_o, busy_o, done_o, escaped_o, illegal_o, cycle_tick_o;
  logic [3:0] div_value_i = 4'h3;
  logic [1:0] wait_states_i = 2'h0, op_len_o;
  logic [7:0] op_byte_i = 8'h00, op_code_o;
  logic [5:0] op_cycles_o;
  int         err_total = 0, checks = 0, m, w, k;
  // plain and escaped ops with their expected length and costs
  row_t rows [11] = '{'{1'b0, 8'h80, 2'h2, 6'h0C, 6'h03}, '{1'b0, 8'h12, 2'h3, 6'h0C, 6'h04},
    '{1'b0, 8'h22, 2'h1, 6'h0C, 6'h04}, '{1'b0, 8'h73, 2'h1, 6'h0C, 6'h02},
    '{1'b0, 8'hB6, 2'h3, 6'h0C, 6'h04}, '{1'b0, 8'hB7, 2'h3, 6'h0C, 6'h04},
    '{1'b0, 8'hD8, 2'h2, 6'h0C, 6'h03}, '{1'b0, 8'h00, 2'h1, 6'h06, 6'h01},
    '{1'b1, 8'h73, 2'h2, 6'h0C, 6'h03}, '{1'b1, 8'hB6, 2'h3, 6'h12, 6'h04},
    '{1'b1, 8'hB7, 2'h3, 6'h12, 6'h04}};
  always #20 sys_clk_i = ~sys_clk_i;
  branch_timing #(.DIV_W(4)) uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .fast_mode_i(fast_mode_i), .div_override_i(div_override_i), .div_value_i(div_value_i),
    .wait_states_i(wait_states_i), .op_valid_i(op_valid_i), .op_byte_i(op_byte_i),
    .op_ready_o(op_ready_o), .busy_o(busy_o), .done_o(done_o), .op_code_o(op_code_o),
    .escaped_o(escaped_o), .op_len_o(op_len_o), .op_cycles_o(op_cycles_o),
    .illegal_o(illegal_o), .cycle_tick_o(cycle_tick_o));
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // offer a byte and hold it until the accept pulse is seen at an edge
  task automatic send(input logic [7:0] b);
    int n;
    op_byte_i <= b;
    op_valid_i <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk_i);
      if (op_ready_o === 1'b1) break;
    end
    if (n == 40) begin
      err_total++;
      final_report();
    end
  endtask
  // divider of 3 keeps the held byte from being taken twice around the accept
  task automatic run_op(input row_t r, input logic [5:0] cyc);
    int n;
    if (r.esc) send(OP_ESCAPE);
    send(r.op);
    op_valid_i <= 1'b0;
    `CHK(op_code_o, r.op)
    `CHK(escaped_o, r.esc)
    `CHK(op_len_o, r.ln)
    `CHK(op_cycles_o, cyc)
    for (n = 0; n < 400; n++) begin
      @(posedge sys_clk_i);
      if (done_o === 1'b1) break;
    end
    `CHK(done_o, 1'b1)
  endtask
  // clocks between two divider ticks
  task automatic tick_gap(input logic fm, input logic ov, input logic [3:0] dv, input int gap);
    int n;
    int t;
    fast_mode_i <= fm;
    div_override_i <= ov;
    div_value_i <= dv;
    repeat (6) @(posedge sys_clk_i);
    for (n = 0; n < 20 && cycle_tick_o !== 1'b1; n++) @(posedge sys_clk_i);
    for (t = 1; t < 20; t++) begin
      @(posedge sys_clk_i);
      if (cycle_tick_o === 1'b1) break;
    end
    `CHK(t, gap)
  endtask
  // escape followed by a byte with no extended meaning
  task automatic bad_escape();
    int n;
    logic seen;
    seen = 1'b0;
    send(OP_ESCAPE);
    send(8'h00);
    op_valid_i <= 1'b0;
    for (n = 0; n < 3; n++) begin
      seen = seen | (illegal_o === 1'b1);
      @(posedge sys_clk_i);
    end
    `CHK(seen, 1'b1)
    `CHK(busy_o, 1'b0)
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    tick_gap(1'b1, 1'b0, 4'h0, 1);
    tick_gap(1'b0, 1'b0, 4'h0, 2);
    tick_gap(1'b1, 1'b1, 4'h5, 5);
    tick_gap(1'b0, 1'b1, 4'h3, 3);
    for (m = 0; m < 2; m++) begin
      fast_mode_i <= m[0];
      @(posedge sys_clk_i);
      for (k = 0; k < 11; k++) run_op(rows[k], m ? rows[k].fc : rows[k].cc);
      for (w = 0; w < 4; w++) begin
        wait_states_i <= w[1:0];
        run_op('{1'b0, {3'b111, w[1], 2'b00, w[0], 1'b0}, 2'h1, 6'h00, 6'h00},
          m ? 6'h02 + 6'(w) : (w != 0 ? 6'h30 : 6'h18));
      end
      bad_escape();
    end
    final_report();
  end
endmodule // tb_branch_timing
`default_nettype wire
